/* File: rtl/i2rc_top.sv */
// two-wire master: rate generation, bus_control behaviour, register port and interrupt
//
// How it works
// - rate code picks divider and hold value
// - bit period is multiplier times divider
// - sda changes hold cycles after scl falls
// - multiplier field selects one, two or four
// - module_on_bit enables the bus engine; register port and interrupt work without it
// - irq_gate_bit gates the interrupt request
// - master_select rising makes start, enters master
// - master_select falling makes stop, leaves master
// - direction bit: zero receive, one transmit
// - ack_suppress sets acknowledge level when receiving
// - repeat_start_request makes repeated start as master
// - repeat_start_request self-clears, always reads zero
// - misplaced repeated start counts as arbitration lost
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module i2rc_top (
  input wire logic CLOCK_IN, // 10 MHz bus clock
  input wire logic RSTN_IN, // async reset, active low
  input wire i2rc_pkg::i2rc_req_t BUS_REQ_IN, // register port request
  output logic [7:0] RDATA_OUT, // read data, cycle after strobe
  output logic IRQ_OUT, // interrupt request level
  input wire logic SCL_IN, // scl pin level
  input wire logic SDA_IN, // sda pin level
  output logic SCL_OUT, // scl drive value, always low
  output logic SCL_OE_OUT, // high while pulling scl low
  output logic SDA_OUT, // sda drive value, always low
  output logic SDA_OE_OUT // high while pulling sda low
);
  import i2rc_pkg::*;

  // software registers
  logic [7:0] rate_q; // rate_multiplier and rate_code
  logic [7:0] ctrl_q; // bus_control
  logic [1:0] stat_q; // sticky events
  logic [7:0] mask_q; // event mask
  logic [7:0] rdata_q; // read data
  logic irq_q; // interrupt output
  logic pin_q; // open-drain drive value
  // pin synchronisers and filtered levels
  logic [2:0] scl_m_q; // scl sampling chain
  logic [2:0] sda_m_q; // sda sampling chain
  logic scl_s_q; // filtered scl
  logic sda_s_q; // filtered sda
  logic sda_p_q; // filtered sda, previous
  logic busy_q; // start seen, stop not yet
  // engine
  i2rc_state_t state_q; // engine state
  logic [13:0] cnt_q; // phase counter
  logic [13:0] half_q; // active half bit period
  logic [9:0] hold_q; // active sda hold
  logic [3:0] bitn_q; // bit within byte
  logic [7:0] shift_q; // byte shifter
  logic [7:0] rx_q; // last received byte
  logic scl_low_q; // pulling scl low
  logic sda_low_q; // pulling sda low
  logic mst_q; // engine owns the bus
  logic rxak_q; // no acknowledge seen
  logic ev_done_q; // byte finished pulse
  logic ev_arb_q; // arbitration lost pulse
  // decoded strobes and rate arithmetic
  logic wr_rate, wr_ctrl, wr_stat, wr_mask, wr_data, rd_data;
  logic [2:0] grp; // rate code group
  logic [2:0] sh; // scaling shift for upper groups
  logic [4:0] idx; // table index
  logic [11:0] div_c; // scl divider
  logic [9:0] hold_c; // sda hold value
  logic [13:0] per_c; // bus clocks per bit
  logic cur_bit; // level of the bit in flight
  logic start_go; // software asks for a start

  // address decode of the register port
  always_comb begin
    wr_rate = 1'b0;
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    wr_data = 1'b0;
    rd_data = 1'b0;
    if (BUS_REQ_IN.addr == I2RC_OFF_RATE) begin
      wr_rate = BUS_REQ_IN.wr;
    end else if (BUS_REQ_IN.addr == I2RC_OFF_CTRL) begin
      wr_ctrl = BUS_REQ_IN.wr;
    end else if (BUS_REQ_IN.addr == I2RC_OFF_STAT) begin
      wr_stat = BUS_REQ_IN.wr;
    end else if (BUS_REQ_IN.addr == I2RC_OFF_MASK) begin
      wr_mask = BUS_REQ_IN.wr;
    end else if (BUS_REQ_IN.addr == I2RC_OFF_DATA) begin
      wr_data = BUS_REQ_IN.wr;
      rd_data = BUS_REQ_IN.rd;
    end
  end

  // divider and hold from the code; upper groups double group 3 per step
  always_comb begin
    grp = rate_q[5:3];
    if (grp >= I2RC_SCALE_GRP) begin
      sh = grp - I2RC_SCALE_GRP;
      idx = {2'h3, rate_q[2:0]};
    end else begin
      sh = 3'h0;
      idx = rate_q[4:0];
    end
    div_c = {4'h0, I2RC_DIV_TBL[idx]} << sh;
    hold_c = (({4'h0, I2RC_HOLD_TBL[idx]} - 10'h001) << sh) + 10'h001;
    // x4 of the largest divider still fits the 14-bit period, no bits dropped
    if (rate_q[7:6] == I2RC_MUL_X2) begin
      per_c = {1'b0, div_c, 1'b0};
    end else if (rate_q[7:6] == I2RC_MUL_X4) begin
      per_c = {div_c, 2'h0};
    end else begin
      per_c = {2'h0, div_c}; // reserved code runs as x1
    end
  end

  // level of the bit now on the wire, acknowledge slot last
  always_comb begin
    if (bitn_q < I2RC_LAST_BIT) begin
      cur_bit = ctrl_q[I2RC_CTL_TX] ? shift_q[7] : 1'b1;
    end else begin
      cur_bit = ctrl_q[I2RC_CTL_TX] ? 1'b1 : ctrl_q[I2RC_CTL_ACK];
    end
    start_go = wr_ctrl && BUS_REQ_IN.wdata[I2RC_CTL_MST] && BUS_REQ_IN.wdata[I2RC_CTL_ON]
               && ctrl_q[I2RC_CTL_ON] && !ctrl_q[I2RC_CTL_MST];
  end

  // pin sampling: a change counts once second and third stage agree
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      scl_m_q <= 3'h7;
      sda_m_q <= 3'h7;
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= {scl_m_q[1:0], SCL_IN};
      sda_m_q <= {sda_m_q[1:0], SDA_IN};
      if (scl_m_q[1] == scl_m_q[2]) begin
        scl_s_q <= scl_m_q[2];
      end
      if (sda_m_q[1] == sda_m_q[2]) begin
        sda_s_q <= sda_m_q[2];
      end
      sda_p_q <= sda_s_q;
    end
  end

  // bus busy from start and stop seen on the wire, any master
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      busy_q <= 1'b0;
    end else if (!ctrl_q[I2RC_CTL_ON]) begin
      busy_q <= 1'b0;
    end else if (scl_s_q && sda_p_q && !sda_s_q) begin
      busy_q <= 1'b1; // start
    end else if (scl_s_q && !sda_p_q && sda_s_q) begin
      busy_q <= 1'b0; // stop
    end
  end

  // rate latch: only between bytes so one byte keeps one bit period
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      half_q <= 14'h000a;
      hold_q <= 10'h007;
    end else if (state_q == ST_IDLE || state_q == ST_WAIT) begin
      half_q <= {1'b0, per_c[13:1]};
      hold_q <= hold_c;
    end
  end

  // rate and mask registers
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rate_q <= I2RC_RATE_RST;
      mask_q <= I2RC_MASK_RST;
    end else begin
      if (wr_rate) begin
        rate_q <= BUS_REQ_IN.wdata;
      end
      if (wr_mask) begin
        mask_q <= BUS_REQ_IN.wdata;
      end
    end
  end

  // bus_control: master_select only sets while enabled, lost bus clears it
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ctrl_q <= I2RC_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= BUS_REQ_IN.wdata;
        ctrl_q[I2RC_CTL_RS] <= 1'b0;
        ctrl_q[I2RC_CTL_MST] <= BUS_REQ_IN.wdata[I2RC_CTL_MST] && BUS_REQ_IN.wdata[I2RC_CTL_ON]
                                && ctrl_q[I2RC_CTL_ON];
      end
      if (ev_arb_q) begin
        ctrl_q[I2RC_CTL_MST] <= 1'b0; // back to slave on loss
      end
    end
  end

  // sticky events: a set in the clearing cycle wins
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      stat_q <= I2RC_STAT_RST;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? BUS_REQ_IN.wdata[1:0] : 2'h0)) | {ev_arb_q, ev_done_q};
    end
  end

  // interrupt level, gated by irq_gate_bit
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ctrl_q[I2RC_CTL_IRQ] && ((stat_q & mask_q[1:0]) != 2'h0);
    end
  end

  // read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rdata_q <= 8'h00;
      pin_q <= 1'b0;
    end else begin
      pin_q <= 1'b0; // open drain only ever drives low
      if (!BUS_REQ_IN.rd) begin
        rdata_q <= 8'h00;
      end else if (BUS_REQ_IN.addr == I2RC_OFF_RATE) begin
        rdata_q <= rate_q;
      end else if (BUS_REQ_IN.addr == I2RC_OFF_CTRL) begin
        rdata_q <= ctrl_q & 8'hfb;
      end else if (BUS_REQ_IN.addr == I2RC_OFF_STAT) begin
        rdata_q <= {busy_q, mst_q, rxak_q, 3'h0, stat_q};
      end else if (BUS_REQ_IN.addr == I2RC_OFF_MASK) begin
        rdata_q <= mask_q;
      end else if (BUS_REQ_IN.addr == I2RC_OFF_DATA) begin
        rdata_q <= rx_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // master engine: start, nine-bit bytes, repeated start, stop, arbitration
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_q <= ST_IDLE;
      cnt_q <= 14'h0000;
      bitn_q <= 4'h0;
      shift_q <= 8'h00;
      rx_q <= 8'h00;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      mst_q <= 1'b0;
      rxak_q <= 1'b0;
      ev_done_q <= 1'b0;
      ev_arb_q <= 1'b0;
    end else begin
      ev_done_q <= 1'b0;
      ev_arb_q <= 1'b0;
      cnt_q <= cnt_q + 14'h0001;
      if (!ctrl_q[I2RC_CTL_ON]) begin
        state_q <= ST_IDLE;
        scl_low_q <= 1'b0;
        sda_low_q <= 1'b0;
        mst_q <= 1'b0;
        cnt_q <= 14'h0000;
      end else if (wr_ctrl && BUS_REQ_IN.wdata[I2RC_CTL_RS] && mst_q && state_q != ST_WAIT) begin
        state_q <= ST_IDLE;
        scl_low_q <= 1'b0;
        sda_low_q <= 1'b0;
        mst_q <= 1'b0;
        ev_arb_q <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            cnt_q <= 14'h0000;
            if (start_go && scl_s_q && sda_s_q && !busy_q) begin
              sda_low_q <= 1'b1;
              mst_q <= 1'b1;
              state_q <= ST_START;
            end else if (start_go) begin
              ev_arb_q <= 1'b1; // bus taken by someone else
            end
          end
          ST_START: begin
            if (cnt_q >= half_q - 14'h0001) begin
              scl_low_q <= 1'b1;
              cnt_q <= 14'h0000;
              state_q <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            cnt_q <= 14'h0000;
            if (wr_ctrl && BUS_REQ_IN.wdata[I2RC_CTL_RS]) begin
              state_q <= ST_RS1;
            end else if (!ctrl_q[I2RC_CTL_MST]) begin
              sda_low_q <= 1'b1;
              state_q <= ST_STOP1;
            end else if (wr_data && ctrl_q[I2RC_CTL_TX]) begin
              shift_q <= BUS_REQ_IN.wdata;
              bitn_q <= 4'h0;
              state_q <= ST_LOW;
            end else if (rd_data && !ctrl_q[I2RC_CTL_TX]) begin
              shift_q <= 8'hff;
              bitn_q <= 4'h0;
              state_q <= ST_LOW;
            end
          end
          ST_LOW: begin
            // counter reads zero in the first low cycle, so hold-1 lands the change hold periods after scl falls
            if (cnt_q == {4'h0, hold_q} - 14'h0001) begin
              sda_low_q <= !cur_bit;
            end
            if (cnt_q >= half_q - 14'h0001) begin
              scl_low_q <= 1'b0;
              cnt_q <= 14'h0000;
              state_q <= ST_HIGH;
            end
          end
          ST_HIGH: begin
            if (!scl_s_q) begin
              cnt_q <= 14'h0000; // stretched by a slave
            end else if (cnt_q >= half_q - 14'h0001) begin
              cnt_q <= 14'h0000;
              if (ctrl_q[I2RC_CTL_TX] && bitn_q < I2RC_LAST_BIT && cur_bit && !sda_s_q) begin
                state_q <= ST_IDLE; // another master drove low
                sda_low_q <= 1'b0;
                mst_q <= 1'b0;
                ev_arb_q <= 1'b1;
              end else begin
                scl_low_q <= 1'b1;
                if (bitn_q < I2RC_LAST_BIT) begin
                  shift_q <= {shift_q[6:0], sda_s_q};
                  bitn_q <= bitn_q + 4'h1;
                  state_q <= ST_LOW;
                end else begin
                  if (ctrl_q[I2RC_CTL_TX]) begin
                    rxak_q <= sda_s_q;
                  end else begin
                    rx_q <= shift_q;
                  end
                  ev_done_q <= 1'b1;
                  state_q <= ST_WAIT;
                end
              end
            end
          end
          ST_STOP1: begin
            if (cnt_q >= half_q - 14'h0001) begin
              scl_low_q <= 1'b0;
              cnt_q <= 14'h0000;
              state_q <= ST_STOP2;
            end
          end
          ST_STOP2: begin
            if (!scl_s_q) begin
              cnt_q <= 14'h0000;
            end else if (cnt_q >= half_q - 14'h0001) begin
              sda_low_q <= 1'b0;
              mst_q <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
          ST_RS1: begin
            if (cnt_q == {4'h0, hold_q} - 14'h0001) begin
              sda_low_q <= 1'b0;
            end
            if (cnt_q >= half_q - 14'h0001) begin
              scl_low_q <= 1'b0;
              cnt_q <= 14'h0000;
              state_q <= ST_RS2;
            end
          end
          ST_RS2: begin
            if (!scl_s_q) begin
              cnt_q <= 14'h0000;
            end else if (cnt_q >= half_q - 14'h0001) begin
              sda_low_q <= 1'b1;
              cnt_q <= 14'h0000;
              state_q <= ST_START;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // outputs straight from flip-flops
  assign RDATA_OUT = rdata_q;
  assign IRQ_OUT = irq_q;
  assign SCL_OUT = pin_q;
  assign SDA_OUT = pin_q;
  assign SCL_OE_OUT = scl_low_q;
  assign SDA_OE_OUT = sda_low_q;

  // checks beside the logic
  AST_RATE_LOW: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    (state_q == ST_IDLE && rate_q == 8'h00) |=> (half_q == 14'h000a && hold_q == 10'h007))
    else $error("rate code 0x00 gives wrong period or hold");
  AST_RATE_TOP: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    ((state_q == ST_IDLE || state_q == ST_WAIT) && rate_q == 8'h3f) |=> (half_q == 14'h0780 && hold_q == 10'h201))
    else $error("rate code 0x3f gives wrong period or hold");
  AST_MUL_TWO: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    (state_q == ST_WAIT && rate_q == 8'h4b) |=> (half_q == 14'h0028))
    else $error("multiplier two with code 0x0b gives wrong period");
  AST_SDA_HOLD: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    ($past(state_q) == ST_LOW && state_q == ST_LOW && $changed(sda_low_q))
    |-> ($past(cnt_q) == {4'h0, $past(hold_q)} - 14'h0001))
    else $error("sda moved away from the hold point");
  AST_RATE_STEADY: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    (state_q == ST_LOW || state_q == ST_HIGH) |=> $stable(half_q) && $stable(hold_q))
    else $error("rate changed inside a byte");
  AST_OFF_RELEASE: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    !ctrl_q[I2RC_CTL_ON] |=> (!SCL_OE_OUT && !SDA_OE_OUT && state_q == ST_IDLE))
    else $error("disabled controller still drives the bus");
  AST_IRQ_GATE: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    !ctrl_q[I2RC_CTL_IRQ] |=> !IRQ_OUT)
    else $error("interrupt raised while gated off");
  AST_START_GEN: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    (state_q == ST_IDLE && start_go && scl_s_q && sda_s_q && !busy_q)
    |=> (state_q == ST_START && SDA_OE_OUT && !SCL_OE_OUT && mst_q))
    else $error("start not generated on master select");
  AST_STOP_GEN: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    (state_q == ST_WAIT && ctrl_q[I2RC_CTL_ON] && !ctrl_q[I2RC_CTL_MST] && !wr_ctrl) |=> state_q == ST_STOP1)
    else $error("stop not begun after master select cleared");
  AST_RS_READ: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    (BUS_REQ_IN.rd && BUS_REQ_IN.addr == I2RC_OFF_CTRL) |=> !RDATA_OUT[I2RC_CTL_RS])
    else $error("repeat start bit read back as one");
  AST_RS_LOST: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    (ctrl_q[I2RC_CTL_ON] && wr_ctrl && BUS_REQ_IN.wdata[I2RC_CTL_RS] && mst_q && state_q == ST_HIGH)
    |=> (state_q == ST_IDLE && !mst_q) ##1 stat_q[I2RC_ST_ARB])
    else $error("misplaced repeated start not reported as lost");
  AST_ACK_LEVEL: assert property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
    (state_q == ST_LOW && bitn_q == I2RC_LAST_BIT && !ctrl_q[I2RC_CTL_TX] && cnt_q == {4'h0, hold_q} - 14'h0001
     && cnt_q < half_q - 14'h0001) |=> (SDA_OE_OUT == !ctrl_q[I2RC_CTL_ACK]))
    else $error("acknowledge slot level wrong");

endmodule : i2rc_top

/* File: rtl/i2rc_pkg.sv */
// shared constants, tables and types of the two-wire rate and control block
package i2rc_pkg;

  // register offsets on the plain register port
  localparam logic [2:0] I2RC_OFF_RATE = 3'h0; // rate_register
  localparam logic [2:0] I2RC_OFF_CTRL = 3'h1; // bus_control
  localparam logic [2:0] I2RC_OFF_STAT = 3'h2; // sticky event status
  localparam logic [2:0] I2RC_OFF_MASK = 3'h3; // event mask
  localparam logic [2:0] I2RC_OFF_DATA = 3'h4; // data byte

  // bus_control field positions
  localparam int unsigned I2RC_CTL_ON = 7; // module_on_bit
  localparam int unsigned I2RC_CTL_IRQ = 6; // irq_gate_bit
  localparam int unsigned I2RC_CTL_MST = 5; // master_select
  localparam int unsigned I2RC_CTL_TX = 4; // direction, 1 transmit
  localparam int unsigned I2RC_CTL_ACK = 3; // ack_suppress
  localparam int unsigned I2RC_CTL_RS = 2; // repeat_start_request

  // status field positions
  localparam int unsigned I2RC_ST_DONE = 0; // byte finished, sticky
  localparam int unsigned I2RC_ST_ARB = 1; // arbitration lost, sticky
  localparam int unsigned I2RC_ST_RXAK = 5; // no acknowledge seen
  localparam int unsigned I2RC_ST_MSTR = 6; // currently bus master
  localparam int unsigned I2RC_ST_BUSY = 7; // bus busy

  // reset values
  localparam logic [7:0] I2RC_RATE_RST = 8'h00;
  localparam logic [7:0] I2RC_CTRL_RST = 8'h00;
  localparam logic [7:0] I2RC_MASK_RST = 8'h00;
  localparam logic [1:0] I2RC_STAT_RST = 2'h0;

  // rate_multiplier encodings
  localparam logic [1:0] I2RC_MUL_X1 = 2'h0;
  localparam logic [1:0] I2RC_MUL_X2 = 2'h1;
  localparam logic [1:0] I2RC_MUL_X4 = 2'h2;

  // rate codes of group 3 and above scale group 3 by powers of two
  localparam logic [2:0] I2RC_SCALE_GRP = 3'h3;
  localparam logic [3:0] I2RC_LAST_BIT = 4'h8; // ninth bit is the acknowledge

  // scl divider and sda hold value for rate codes 0x00 to 0x1f
  localparam logic [0:31][7:0] I2RC_DIV_TBL = {
    8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e, 8'h22, 8'h28,
    8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h38, 8'h44,
    8'h30, 8'h38, 8'h40, 8'h48, 8'h50, 8'h58, 8'h68, 8'h80,
    8'h50, 8'h60, 8'h70, 8'h80, 8'h90, 8'ha0, 8'hc0, 8'hf0};
  localparam logic [0:31][5:0] I2RC_HOLD_TBL = {
    6'h07, 6'h07, 6'h08, 6'h08, 6'h09, 6'h09, 6'h0a, 6'h0a,
    6'h07, 6'h07, 6'h09, 6'h09, 6'h0b, 6'h0b, 6'h0d, 6'h0d,
    6'h09, 6'h09, 6'h0d, 6'h0d, 6'h11, 6'h11, 6'h15, 6'h15,
    6'h09, 6'h09, 6'h11, 6'h11, 6'h19, 6'h19, 6'h21, 6'h21};

  // one register port request
  typedef struct packed {
    logic [2:0] addr; // register offset
    logic [7:0] wdata; // write data
    logic wr; // write strobe
    logic rd; // read strobe
  } i2rc_req_t;

  // master engine states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_START = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_LOW = 4'b0011,
    ST_HIGH = 4'b0100,
    ST_STOP1 = 4'b0101,
    ST_STOP2 = 4'b0110,
    ST_RS1 = 4'b0111,
    ST_RS2 = 4'b1000
  } i2rc_state_t;

endpackage : i2rc_pkg

/* File: testbench/i2rc_bus_model.sv */
// behavioural slave on the shared two-wire bus: acks, captures or sends a byte
`timescale 1ns/1ps
module i2rc_bus_model (
  input wire logic scl_in, // scl wire level
  input wire logic sda_in, // sda wire level
  input wire logic send_en_in, // slave drives the next byte
  input wire logic [7:0] send_byte_in, // byte to drive
  output logic sda_oe_out, // high while pulling sda low
  output logic [7:0] got_byte_out, // eight data bits of the last byte
  output logic got_ack_out, // ninth bit seen low
  output int starts_out, // start conditions seen
  output logic stop_out // stop seen since last start
);
  int cnt = 0; // bits clocked in the current byte
  int pos = 0; // bit slot being driven
  // start: sda falls while scl high, restarts the bit count
  always @(negedge sda_in) if (scl_in) begin
    cnt = 0;
    pos = 0;
    starts_out++;
    stop_out = 1'b0;
  end
  // stop: sda rises while scl high
  always @(posedge sda_in) if (scl_in) stop_out = 1'b1;
  // sample on rising scl; ninth bit is the acknowledge
  always @(posedge scl_in) begin
    if (cnt < 8) got_byte_out = {got_byte_out[6:0], sda_in};
    else got_ack_out = !sda_in;
    cnt++;
  end
  // move to the next slot two bus periods after scl falls, a real hold time
  always @(negedge scl_in) begin
    #200;
    if (cnt > 8) cnt = 0;
    pos = cnt;
  end
  // released line shows the pull-up, never a stale value
  assign sda_oe_out = send_en_in ? (pos < 8 && !send_byte_in[7 - pos]) : (pos == 8);
endmodule : i2rc_bus_model

/* File: testbench/i2rc_top_tb.sv */
// self-checking bench: registers, rates, transfers, restart, stop, interrupt
`timescale 1ns/1ps
module i2rc_top_tb;
  import i2rc_pkg::*;
  logic clk = 1'b0; // 10 MHz bus clock
  logic rstn = 1'b0; // reset, active low
  i2rc_req_t req = '0; // register request
  logic [7:0] rdata, v, got, send_byte = 8'h00;
  logic irq, scl_oe, sda_oe, scl_o, sda_o, m_oe, got_ack, stop_seen, send_en = 1'b0;
  logic p_scl = 1'b0, p_sda = 1'b0; // enables one edge ago
  int starts, n_errors = 0, samples_checked = 0, cyc = 0, last = 0, pmin, pmax, hmin, hmax;
  bit seen = 1'b0; // a scl pull-low start seen since clear
  wire scl = !scl_oe; // pull-up unless someone pulls low
  wire sda = !(sda_oe | m_oe);
  always #50 clk = ~clk;
  i2rc_top DUT (.CLOCK_IN(clk), .RSTN_IN(rstn), .BUS_REQ_IN(req), .RDATA_OUT(rdata), .IRQ_OUT(irq), .SCL_IN(scl),
    .SDA_IN(sda), .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe));
  i2rc_bus_model PEER (.scl_in(scl), .sda_in(sda), .send_en_in(send_en), .send_byte_in(send_byte),
    .sda_oe_out(m_oe), .got_byte_out(got), .got_ack_out(got_ack), .starts_out(starts), .stop_out(stop_seen));
  // scl period between pull-low starts, sda hold after scl pulled low
  always @(posedge clk) begin
    cyc++;
    if (scl_oe && !p_scl) begin
      if (seen && cyc - last < pmin) pmin = cyc - last;
      if (seen && cyc - last > pmax) pmax = cyc - last;
      last = cyc;
      seen = 1'b1;
    end else if (seen && scl_oe && sda_oe != p_sda) begin
      if (cyc - last < hmin) hmin = cyc - last;
      if (cyc - last > hmax) hmax = cyc - last;
    end
    p_scl = scl_oe;
    p_sda = sda_oe;
  end
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    d = rdata;
  endtask : rd
  task automatic rdchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a, v);
    chk(v & m, e);
  endtask : rdchk
  // bounded poll of the byte-done flag
  task automatic wait_done;
    for (int i = 0; i < 30000; i++) begin
      rd(I2RC_OFF_STAT, v);
      if (v[I2RC_ST_DONE] === 1'b1) return;
    end
    n_errors++;
    $display("Error at %0t: transfer never finished", $time);
    test_done;
  endtask : wait_done
  initial begin
    logic [7:0] rt [4] = '{8'h00, 8'h4b, 8'h87, 8'h3f};
    int per [4] = '{20, 80, 160, 3840};
    int hld [4] = '{7, 9, 10, 513};
    logic [2:0] ia [5] = '{I2RC_OFF_MASK, I2RC_OFF_CTRL, I2RC_OFF_MASK, I2RC_OFF_MASK, I2RC_OFF_STAT};
    logic [7:0] id [5] = '{8'h02, 8'hc0, 8'h00, 8'h02, 8'h02};
    logic [7:0] ie [5] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // reset values, unmapped offsets read zero
    for (int a = 0; a < 8; a++) if (a != 4) rdchk(3'(a), 8'hff, 8'h00);
    wr(I2RC_OFF_CTRL, 8'h80);
    rdchk(I2RC_OFF_CTRL, 8'hff, 8'h80);
    wr(I2RC_OFF_CTRL, 8'hb0);
    repeat (30) @(posedge clk);
    chk(8'(starts), 8'h01);
    chk(8'({scl_o, sda_o, scl_oe, sda_oe}), 8'h03);
    rdchk(I2RC_OFF_STAT, 8'h40, 8'h40);
    // one byte per rate setting, rate changed between bytes
    for (int i = 0; i < 4; i++) begin
      wr(I2RC_OFF_RATE, rt[i]);
      #1;
      seen = 1'b0;
      pmin = 1 << 20;
      pmax = 0;
      hmin = 1 << 20;
      hmax = 0;
      wr(I2RC_OFF_DATA, rt[i] ^ 8'ha5);
      wait_done;
      chk(got, rt[i] ^ 8'ha5);
      chk(8'(pmin >= per[i] && pmax <= per[i] + 6), 8'h01);
      chk(8'(hmin == hld[i] && hmax == hld[i]), 8'h01);
      rdchk(I2RC_OFF_STAT, 8'h20, 8'h00);
      wr(I2RC_OFF_STAT, 8'h01);
    end
    wr(I2RC_OFF_RATE, 8'h00);
    // receive with ack then without; switch to transmit before reading data
    for (int k = 0; k < 2; k++) begin
      wr(I2RC_OFF_CTRL, k ? 8'ha8 : 8'ha0);
      send_byte = k ? 8'hc3 : 8'h3c;
      send_en = 1'b1;
      rd(I2RC_OFF_DATA, v);
      wait_done;
      send_en = 1'b0;
      chk(8'(got_ack), 8'(!k));
      wr(I2RC_OFF_CTRL, 8'hb0);
      rdchk(I2RC_OFF_DATA, 8'hff, send_byte);
      wr(I2RC_OFF_STAT, 8'h01);
    end
    wr(I2RC_OFF_CTRL, 8'hb4);
    repeat (80) @(posedge clk);
    chk(8'(starts), 8'h02);
    rdchk(I2RC_OFF_CTRL, 8'hff, 8'hb0);
    wr(I2RC_OFF_CTRL, 8'h90);
    repeat (80) @(posedge clk);
    chk(8'(stop_seen), 8'h01);
    rdchk(I2RC_OFF_STAT, 8'hc0, 8'h00);
    // restart requested mid-byte ends as lost arbitration
    wr(I2RC_OFF_CTRL, 8'hb0);
    repeat (30) @(posedge clk);
    wr(I2RC_OFF_DATA, 8'hff);
    repeat (12) @(posedge clk);
    wr(I2RC_OFF_CTRL, 8'hb4);
    rdchk(I2RC_OFF_STAT, 8'h42, 8'h02);
    chk(8'({scl_oe, sda_oe, irq}), 8'h00);
    // gate, mask and clear of the interrupt level
    for (int j = 0; j < 5; j++) begin
      wr(ia[j], id[j]);
      @(posedge clk);
      #1;
      chk(8'(irq), ie[j]);
    end
    wr(I2RC_OFF_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    chk(8'({scl_oe, sda_oe}), 8'h00);
    test_done;
  end
endmodule : i2rc_top_tb
